// file: cbi_params.svh
// Timing counts, addresses and reset values of the bus sequencer
`ifndef CBI_PARAMS_SVH
`define CBI_PARAMS_SVH
`define CBI_RESET_PC 16'h0000
`define CBI_NMI_VEC 16'h0066
`define CBI_IM1_VEC 16'h0038
`define CBI_IM_RESET 2'h0
`define CBI_IM_FAST 2'h1
`define CBI_T_FIRST 3'h1
`define CBI_T_FETCH_DATA 3'h2
`define CBI_T_FETCH_LEG 3'h4
`define CBI_T_FETCH_FAST 3'h3
`define CBI_T_MEM 3'h3
`define CBI_T_PORT 3'h4
`define CBI_WAIT_MEM 3'h2
`define CBI_WAIT_PORT 3'h3
`define CBI_RFSH_RESET 7'h00
`define CBI_RFSH_HIGH 9'h000
`define CBI_SYNC_IDLE 5'h1F
`endif

// file: cbi_pkg.sv
// Types shared by the bus sequencer and its users
`default_nettype none
package cbi_pkg;
   typedef enum logic [2:0] {
      CBI_FETCH = 3'h0,
      CBI_MEM_RD = 3'h1,
      CBI_MEM_WR = 3'h2,
      CBI_PORT_RD = 3'h3,
      CBI_PORT_WR = 3'h4
   } cbi_kind_t;
   typedef enum logic [3:0] {
      CBI_IDLE = 4'h1,
      CBI_CYCLE = 4'h2,
      CBI_GAP = 4'h4,
      CBI_HELD = 4'h8
   } cbi_ctl_t;
   typedef struct packed {
      cbi_kind_t kind;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cbi_req_t;
   typedef struct packed {
      logic done;
      logic halt;
      logic jump;
      logic [15:0] target;
      logic set_ie;
      logic clr_ie;
      logic set_im;
      logic [1:0] im;
   } cbi_instr_t;
   typedef struct packed {
      logic taken;
      logic nmi;
      logic [1:0] mode;
      logic [15:0] push_pc;
   } cbi_irq_t;
   typedef struct packed {
      logic [15:0] addr;
      logic addr_oe;
      logic [7:0] dout;
      logic dout_oe;
      logic machine_cycle_one_n;
      logic legacy_oe;
      logic memory_request_n;
      logic port_request_n;
      logic read_strobe_n;
      logic write_strobe_n;
      logic fast_oe;
      logic memory_read_n;
      logic memory_store_n;
      logic port_read_n;
      logic port_store_n;
   } cbi_pins_t;
endpackage: cbi_pkg
`default_nettype wire

// file: cbi_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module cbi_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] IDLE = '0
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Raw pins and clean levels
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level
);
   logic [W-1:0] s1_r, s2_r, s3_r, level_r, level_nxt;

   // First stage feeds only the second
   always_comb begin
      level_nxt = level_r;
      for (int i = 0; i < W; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            level_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s1_r <= IDLE;
         s2_r <= IDLE;
         s3_r <= IDLE;
         level_r <= IDLE;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         level_r <= level_nxt;
      end
   end

   assign level = level_r;
endmodule: cbi_pin_sync
`default_nettype wire

// file: cbi_bus_seq.sv
// External bus sequencer: cycles, prefetch, bus release, interrupts, halt
`default_nettype none
`include "cbi_params.svh"
module cbi_bus_seq (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Bus pins
   input wire logic [7:0] data_in,
   input wire logic stall_n,
   input wire logic bus_hold_req_n,
   input wire logic nonmask_irq_n,
   input wire logic maskable_irq_n,
   input wire logic mode_select,
   output cbi_pkg::cbi_pins_t pins,
   output logic bus_grant_n,
   output logic stopped_n,
   // Core data requests
   input wire logic req_valid,
   input wire cbi_pkg::cbi_req_t req,
   output logic req_ready,
   output logic rsp_done,
   output logic [7:0] rsp_data,
   // Core instruction flow
   input wire cbi_pkg::cbi_instr_t instr,
   output logic op_valid,
   output logic [7:0] op_byte,
   output cbi_pkg::cbi_irq_t irq
);
   localparam cbi_pkg::cbi_pins_t PINS_RST = '{addr: 16'h0000,
      dout: 8'h00, addr_oe: 1'h0, dout_oe: 1'h0, legacy_oe: 1'h0,
      fast_oe: 1'h0, default: 1'h1};

   logic stall_s, hold_s, nmi_s, int_s, mode_s;
   cbi_pkg::cbi_ctl_t ctl_r, ctl_nxt;
   cbi_pkg::cbi_kind_t kind_r, kind_nxt, st_kind;
   logic [2:0] tcnt_r, tcnt_nxt;
   logic wait_r, wait_nxt, legacy_r, legacy_nxt;
   logic [15:0] addr_r, addr_nxt, pc_r, pc_nxt, st_addr;
   logic [7:0] wdata_r, wdata_nxt, cap_r, cap_nxt, cap_val;
   logic [7:0] op_byte_r, op_byte_nxt, rsp_data_r, rsp_data_nxt;
   logic op_valid_r, op_valid_nxt, chk_r, chk_nxt, boot_r, boot_nxt;
   logic halt_r, halt_nxt, nmi_pend_r, nmi_pend_nxt, nmi_prev_r;
   logic irq_enable_ff_r, irq_enable_ff_nxt, rsp_done_r, rsp_done_nxt, st;
   logic [1:0] im_r, im_nxt, eff_im;
   logic [6:0] rfsh_r, rfsh_nxt;
   cbi_pkg::cbi_irq_t irq_r, irq_nxt;
   cbi_pkg::cbi_pins_t pins_r, pins_nxt;
   logic grant_n_r, grant_n_nxt, stop_n_r, stop_n_nxt;
   logic adv, cap_now, end_now, irq_go, cyc_t1;
   logic in_cyc, own, pk, wk, fk, lf, early, late;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   function automatic logic is_port(cbi_pkg::cbi_kind_t k);
      return k == cbi_pkg::CBI_PORT_RD || k == cbi_pkg::CBI_PORT_WR;
   endfunction: is_port

   function automatic logic is_write(cbi_pkg::cbi_kind_t k);
      return k == cbi_pkg::CBI_MEM_WR || k == cbi_pkg::CBI_PORT_WR;
   endfunction: is_write

   function automatic logic [2:0] cyc_last(cbi_pkg::cbi_kind_t k,
                                           logic leg);
      logic [2:0] n;
      n = `CBI_T_MEM;
      if (k == cbi_pkg::CBI_FETCH) begin
         n = leg ? `CBI_T_FETCH_LEG : `CBI_T_FETCH_FAST;
      end else if (is_port(k)) begin
         n = `CBI_T_PORT;
      end
      return n;
   endfunction: cyc_last

   cbi_pin_sync #(.W(5), .IDLE(`CBI_SYNC_IDLE)) u_sync (
      .clock (clock),
      .rst_b (rst_b),
      .pin ({mode_select, maskable_irq_n, nonmask_irq_n, bus_hold_req_n,
             stall_n}),
      .level ({mode_s, int_s, nmi_s, hold_s, stall_s})
   );

   // Cycle progress decode
   always_comb begin
      eff_im = legacy_r ? im_r : `CBI_IM_FAST;
      if (wait_r) begin
         adv = stall_s;
      end else begin
         adv = !(!stall_s && tcnt_r == (is_port(kind_r) ? `CBI_WAIT_PORT
                                                         : `CBI_WAIT_MEM));
      end
      cyc_t1 = ctl_r == cbi_pkg::CBI_CYCLE && tcnt_r == `CBI_T_FIRST;
      cap_now = ctl_r == cbi_pkg::CBI_CYCLE && adv &&
         tcnt_r == ((kind_r == cbi_pkg::CBI_FETCH && legacy_r) ?
                    `CBI_T_FETCH_DATA : cyc_last(kind_r, legacy_r));
      end_now = ctl_r == cbi_pkg::CBI_CYCLE && adv &&
         tcnt_r == cyc_last(kind_r, legacy_r);
      cap_val = cap_now ? data_in : cap_r;
      irq_go = nmi_pend_r || (!int_s && irq_enable_ff_r);
   end

   // Sequencer next state
   always_comb begin
      ctl_nxt = ctl_r;
      tcnt_nxt = tcnt_r;
      wait_nxt = wait_r;
      kind_nxt = kind_r;
      legacy_nxt = legacy_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      pc_nxt = pc_r;
      cap_nxt = cap_r;
      op_byte_nxt = op_byte_r;
      op_valid_nxt = op_valid_r;
      rsp_data_nxt = rsp_data_r;
      rsp_done_nxt = 1'h0;
      chk_nxt = chk_r;
      boot_nxt = boot_r;
      halt_nxt = halt_r;
      nmi_pend_nxt = nmi_pend_r;
      irq_enable_ff_nxt = irq_enable_ff_r;
      im_nxt = im_r;
      rfsh_nxt = rfsh_r;
      irq_nxt = irq_r;
      irq_nxt.taken = 1'h0;
      st = 1'h0;
      st_kind = cbi_pkg::CBI_FETCH;
      st_addr = addr_r;
      unique case (ctl_r)
         cbi_pkg::CBI_IDLE: begin
            legacy_nxt = mode_s;
            if (!hold_s) begin
               ctl_nxt = cbi_pkg::CBI_HELD;
            end else if (boot_r) begin
               boot_nxt = 1'h0;
               st = 1'h1;
               st_addr = pc_r;
            end else if (chk_r || halt_r) begin
               chk_nxt = 1'h0;
               if (irq_go) begin
                  // discard prefetch, push PC minus one
                  halt_nxt = 1'h0;
                  op_valid_nxt = 1'h0;
                  irq_enable_ff_nxt = 1'h0;
                  irq_nxt.taken = 1'h1;
                  irq_nxt.nmi = nmi_pend_r;
                  irq_nxt.mode = eff_im;
                  irq_nxt.push_pc = pc_r - 16'h0001;
                  nmi_pend_nxt = 1'h0;
                  // fixed entry only for NMI or mode 1
                  if (nmi_pend_r || eff_im == `CBI_IM_FAST) begin
                     pc_nxt = nmi_pend_r ? `CBI_NMI_VEC : `CBI_IM1_VEC;
                     st = 1'h1;
                     st_addr = pc_nxt;
                  end
               end else if (halt_r) begin
                  ctl_nxt = cbi_pkg::CBI_GAP;
               end
            end else if (instr.done) begin
               op_valid_nxt = 1'h0;
               if (instr.set_ie) begin
                  irq_enable_ff_nxt = 1'h1;
               end
               if (instr.clr_ie) begin
                  irq_enable_ff_nxt = 1'h0;
               end
               if (instr.set_im) begin
                  im_nxt = instr.im;
               end
               if (instr.halt) begin
                  halt_nxt = 1'h1;
                  ctl_nxt = cbi_pkg::CBI_GAP;
               end else begin
                  pc_nxt = instr.jump ? instr.target : pc_r;
                  st = 1'h1;
                  st_addr = pc_nxt;
                  chk_nxt = 1'h1;
               end
            end else if (req_valid) begin
               st = 1'h1;
               st_kind = req.kind;
               st_addr = req.addr;
               wdata_nxt = req.wdata;
            end
         end
         cbi_pkg::CBI_GAP: begin
            // Halt fetch re-reads the halt opcode byte itself
            st = 1'h1;
            st_addr = pc_r - 16'h0001;
         end
         cbi_pkg::CBI_CYCLE: begin
            if (cap_now) begin
               cap_nxt = data_in;
            end
            if (wait_r) begin
               if (stall_s) begin
                  wait_nxt = 1'h0;
                  tcnt_nxt = tcnt_r + 3'h1;
               end
            end else if (!adv) begin
               wait_nxt = 1'h1;
            end else if (end_now) begin
               ctl_nxt = cbi_pkg::CBI_IDLE;
               if (kind_r == cbi_pkg::CBI_FETCH) begin
                  rfsh_nxt = rfsh_r + 7'h01;
                  if (!halt_r) begin
                     op_byte_nxt = cap_val;
                     op_valid_nxt = 1'h1;
                     pc_nxt = pc_r + 16'h0001;
                  end
               end else begin
                  rsp_done_nxt = 1'h1;
                  rsp_data_nxt = cap_val;
               end
            end else begin
               tcnt_nxt = tcnt_r + 3'h1;
            end
         end
         cbi_pkg::CBI_HELD: begin
            if (hold_s) begin
               ctl_nxt = cbi_pkg::CBI_IDLE;
            end
         end
         default: begin
            ctl_nxt = cbi_pkg::CBI_IDLE;
         end
      endcase
      if (st) begin
         ctl_nxt = cbi_pkg::CBI_CYCLE;
         tcnt_nxt = `CBI_T_FIRST;
         wait_nxt = 1'h0;
         kind_nxt = st_kind;
         addr_nxt = st_addr;
         legacy_nxt = mode_s;
      end
      // latched edge wins over its clear
      if (nmi_prev_r && !nmi_s) begin
         nmi_pend_nxt = 1'h1;
      end
   end

   // Pin levels for the coming state, registered to avoid glitches
   always_comb begin
      in_cyc = ctl_nxt == cbi_pkg::CBI_CYCLE;
      own = ctl_nxt != cbi_pkg::CBI_HELD;
      pk = is_port(kind_nxt);
      wk = is_write(kind_nxt);
      fk = kind_nxt == cbi_pkg::CBI_FETCH;
      lf = in_cyc && fk && legacy_nxt;
      early = tcnt_nxt <= `CBI_T_FETCH_DATA;
      late = tcnt_nxt > `CBI_T_FIRST;
      pins_nxt = PINS_RST;
      // refresh address in the back half of a legacy fetch
      pins_nxt.addr = (lf && !early) ? {`CBI_RFSH_HIGH, rfsh_nxt} : addr_nxt;
      pins_nxt.addr_oe = own;
      pins_nxt.dout = wdata_nxt;
      pins_nxt.dout_oe = in_cyc && wk;
      // cycle-one only in legacy fetch front half
      pins_nxt.machine_cycle_one_n = !(lf && early);
      pins_nxt.legacy_oe = own && legacy_nxt;
      pins_nxt.memory_request_n = !(in_cyc && !pk && (!fk || early));
      pins_nxt.port_request_n = !(in_cyc && pk && late);
      pins_nxt.read_strobe_n = !(in_cyc && !wk &&
                                 (fk ? early : (!pk || late)));
      pins_nxt.write_strobe_n = !(in_cyc && wk && late);
      pins_nxt.fast_oe = own && !legacy_nxt;
      pins_nxt.memory_read_n = !(in_cyc && !pk && !wk);
      pins_nxt.memory_store_n = !(in_cyc && !pk && wk && late);
      pins_nxt.port_read_n = !(in_cyc && pk && !wk && late);
      pins_nxt.port_store_n = !(in_cyc && pk && wk && late);
      grant_n_nxt = own;
      stop_n_nxt = !halt_nxt;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         // fetch from 0000H, mode 0, enable clear
         ctl_r <= cbi_pkg::CBI_IDLE;
         tcnt_r <= `CBI_T_FIRST;
         wait_r <= 1'h0;
         kind_r <= cbi_pkg::CBI_FETCH;
         legacy_r <= 1'h1;
         addr_r <= `CBI_RESET_PC;
         pc_r <= `CBI_RESET_PC;
         wdata_r <= 8'h00;
         cap_r <= 8'h00;
         op_byte_r <= 8'h00;
         op_valid_r <= 1'h0;
         rsp_data_r <= 8'h00;
         rsp_done_r <= 1'h0;
         chk_r <= 1'h0;
         boot_r <= 1'h1;
         halt_r <= 1'h0;
         nmi_pend_r <= 1'h0;
         nmi_prev_r <= 1'h1;
         irq_enable_ff_r <= 1'h0;
         im_r <= `CBI_IM_RESET;
         rfsh_r <= `CBI_RFSH_RESET;
         irq_r <= '0;
         pins_r <= PINS_RST;
         grant_n_r <= 1'h1;
         stop_n_r <= 1'h1;
      end else begin
         ctl_r <= ctl_nxt;
         tcnt_r <= tcnt_nxt;
         wait_r <= wait_nxt;
         kind_r <= kind_nxt;
         legacy_r <= legacy_nxt;
         addr_r <= addr_nxt;
         pc_r <= pc_nxt;
         wdata_r <= wdata_nxt;
         cap_r <= cap_nxt;
         op_byte_r <= op_byte_nxt;
         op_valid_r <= op_valid_nxt;
         rsp_data_r <= rsp_data_nxt;
         rsp_done_r <= rsp_done_nxt;
         chk_r <= chk_nxt;
         boot_r <= boot_nxt;
         halt_r <= halt_nxt;
         nmi_pend_r <= nmi_pend_nxt;
         nmi_prev_r <= nmi_s;
         irq_enable_ff_r <= irq_enable_ff_nxt;
         im_r <= im_nxt;
         rfsh_r <= rfsh_nxt;
         irq_r <= irq_nxt;
         pins_r <= pins_nxt;
         grant_n_r <= grant_n_nxt;
         stop_n_r <= stop_n_nxt;
      end
   end

   // Interrupt check and halt block the core until resolved
   assign req_ready = ctl_r == cbi_pkg::CBI_IDLE && hold_s && !boot_r &&
                      !chk_r && !halt_r;
   assign pins = pins_r;
   assign bus_grant_n = grant_n_r;
   assign stopped_n = stop_n_r;
   assign rsp_done = rsp_done_r;
   assign rsp_data = rsp_data_r;
   assign op_valid = op_valid_r;
   assign op_byte = op_byte_r;
   assign irq = irq_r;

   fetch_len_a:
      assert property (cyc_t1 && kind_r == cbi_pkg::CBI_FETCH && legacy_r
                       ##1 stall_s |-> ##2 end_now)
      else $error("legacy fetch not four clocks");
   mem_len_a:
      assert property (cyc_t1 && (kind_r == cbi_pkg::CBI_MEM_RD ||
                       kind_r == cbi_pkg::CBI_MEM_WR) ##1 stall_s
                       |-> ##1 end_now && pins_r.machine_cycle_one_n)
      else $error("memory cycle not three clocks");
   fast_fetch_a:
      assert property (cyc_t1 && kind_r == cbi_pkg::CBI_FETCH && !legacy_r
                       ##1 stall_s |-> ##1 end_now)
      else $error("fast fetch not three clocks");
   port_min_a:
      assert property (cyc_t1 && is_port(kind_r) |-> (!end_now)[*3])
      else $error("port cycle shorter than four");
   port_wait_a:
      assert property (ctl_r == cbi_pkg::CBI_CYCLE && is_port(kind_r) &&
                       tcnt_r == `CBI_WAIT_PORT && !wait_r && !stall_s
                       |=> wait_r && tcnt_r == `CBI_WAIT_PORT)
      else $error("port wait not inserted at third state");
   fetch_wait_a:
      assert property (ctl_r == cbi_pkg::CBI_CYCLE &&
                       kind_r == cbi_pkg::CBI_FETCH &&
                       tcnt_r == `CBI_WAIT_MEM && !wait_r && !stall_s
                       |=> wait_r && tcnt_r == `CBI_WAIT_MEM)
      else $error("fetch wait not inserted at second state");
   fetch_strobe_a:
      assert property (cyc_t1 && kind_r == cbi_pkg::CBI_FETCH && legacy_r
                       |-> !pins_r.memory_request_n &&
                       !pins_r.read_strobe_n &&
                       !pins_r.machine_cycle_one_n)
      else $error("fetch strobes not all low");
   refresh_a:
      assert property (ctl_r == cbi_pkg::CBI_CYCLE && legacy_r &&
                       kind_r == cbi_pkg::CBI_FETCH &&
                       tcnt_r > `CBI_T_FETCH_DATA
                       |-> pins_r.addr == {`CBI_RFSH_HIGH, rfsh_r})
      else $error("refresh address missing");
   hold_float_a:
      assert property (ctl_r == cbi_pkg::CBI_HELD |-> !pins_r.addr_oe &&
                       !pins_r.dout_oe && !pins_r.legacy_oe &&
                       !pins_r.fast_oe && !bus_grant_n && !irq_r.taken)
      else $error("bus not floated while held");
   hold_exit_a:
      assert property (ctl_r == cbi_pkg::CBI_HELD |=> ctl_r ==
                       ($past(hold_s) ? cbi_pkg::CBI_IDLE : cbi_pkg::CBI_HELD))
      else $error("hold release wrong");
   nmi_vec_a:
      assert property (irq_r.taken && irq_r.nmi |-> addr_r == `CBI_NMI_VEC
                       && ctl_r == cbi_pkg::CBI_CYCLE)
      else $error("nmi did not fetch its entry");
   discard_a:
      assert property (irq_r.taken |-> !op_valid_r &&
                       irq_r.push_pc == $past(pc_r) - 16'h0001)
      else $error("prefetch not discarded on interrupt");
   halt_pin_a:
      assert property (halt_r |-> !stopped_n)
      else $error("stopped pin high in halt");
   fast_pin_a:
      assert property (ctl_r != cbi_pkg::CBI_HELD && !legacy_r
                       |-> pins_r.fast_oe && !pins_r.legacy_oe)
      else $error("fast strobes not driven");

   cover property (ctl_r == cbi_pkg::CBI_CYCLE && wait_r);
   cover property (irq_r.taken && irq_r.nmi);
   cover property (ctl_r == cbi_pkg::CBI_HELD);
   cover property (halt_r ##1 irq_r.taken);
endmodule: cbi_bus_seq
`default_nettype wire

// file: cbi_mem_model.sv
// Memory and port partner: read data and wait pin
`default_nettype none
module cbi_mem_model (
   // Clock and bus
   input wire logic clock,
   input wire cbi_pkg::cbi_pins_t pins,
   input wire logic slow,
   // Answers
   output logic [7:0] data_in,
   output logic stall_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last = 8'h00;
   int low = 0;
   wire logic rd = (pins.legacy_oe && !pins.read_strobe_n) ||
      (pins.fast_oe && !(pins.memory_read_n && pins.port_read_n));
   // No pull-up on data, so an idle bus shows the inverse
   assign data_in = rd ? pins.addr[7:0] ^ pins.addr[15:8] ^ 8'h5A : ~last;
   // Slow device holds stall until six legacy request strobe clocks; fast-mode strobes are not counted
   assign stall_n = !(slow && low < 6);
   always @(posedge clock) begin
      if (rd) last <= data_in;
      low <= (pins.legacy_oe &&
         !(pins.memory_request_n && pins.port_request_n)) ? low + 1 : 0;
   end
endmodule: cbi_mem_model
`default_nettype wire

// file: cbi_bus_seq_tb.sv
// Self-checking bench for the bus sequencer
`default_nettype none
module cbi_bus_seq_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic stall_n, bus_grant_n, stopped_n, req_ready, rsp_done, op_valid;
   logic bus_hold_req_n = 1'b1;
   logic nonmask_irq_n = 1'b1;
   logic maskable_irq_n = 1'b1;
   logic mode_select = 1'b1;
   logic req_valid = 1'b0;
   logic slow = 1'b0;
   logic [7:0] data_in, rsp_data, op_byte;
   logic [15:0] a;
   logic [8:0] d;
   logic [3:0] sig;
   cbi_pkg::cbi_req_t req = '0;
   cbi_pkg::cbi_instr_t instr = '0;
   cbi_pkg::cbi_pins_t pins;
   cbi_pkg::cbi_irq_t irq;
   int errors = 0;
   int n_checks = 0;
   int n;
   int cyc = 0;
   int c0 = 0;
   cbi_bus_seq cbi_bus_seq_i (.clock(clock), .rst_b(rst_b),
      .data_in(data_in), .stall_n(stall_n),
      .bus_hold_req_n(bus_hold_req_n), .nonmask_irq_n(nonmask_irq_n),
      .maskable_irq_n(maskable_irq_n), .mode_select(mode_select),
      .pins(pins),
      .bus_grant_n(bus_grant_n), .stopped_n(stopped_n),
      .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp_done(rsp_done), .rsp_data(rsp_data), .instr(instr),
      .op_valid(op_valid), .op_byte(op_byte), .irq(irq));
   cbi_mem_model cbi_mem_model_i (.clock(clock), .pins(pins),
      .slow(slow), .data_in(data_in), .stall_n(stall_n));
   initial forever #12.5 clock = ~clock;
   // Edge count for cycle lengths seen from the core side
   always @(posedge clock) cyc <= cyc + 1;
   function automatic logic [7:0] mem(input logic [15:0] ad);
      return ad[7:0] ^ ad[15:8] ^ 8'h5A;
   endfunction: mem
   function automatic logic act();
      return (pins.legacy_oe === 1'b1 &&
         !(pins.memory_request_n && pins.port_request_n)) ||
         (pins.fast_oe === 1'b1 && !(&{pins.memory_read_n,
         pins.memory_store_n, pins.port_read_n, pins.port_store_n}));
   endfunction: act
   function automatic logic hit(input int s);
      case (s)
         0: return req_ready === 1'b1;
         1: return rsp_done === 1'b1;
         2: return bus_grant_n === 1'b0;
         3: return bus_grant_n === 1'b1;
         4: return stopped_n === 1'b0;
         default: return irq.taken === 1'b1;
      endcase
   endfunction: hit
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask: chk
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask: wrap_up
   task automatic bwait(input int s);
      for (int i = 0; i < 80 && !hit(s); i++) @(negedge clock);
      if (!hit(s)) begin
         chk(16'h0, 16'h1);
         wrap_up();
      end
   endtask: bwait
   // Strobe length, address and strobe pattern of the next bus cycle
   task automatic watch;
      n = 0;
      for (int i = 0; i < 80 && !act(); i++) @(negedge clock);
      a = pins.addr;
      d = {pins.dout_oe, pins.dout};
      sig = pins.legacy_oe ? {pins.machine_cycle_one_n,
         pins.memory_request_n, pins.port_request_n, pins.read_strobe_n} :
         {pins.machine_cycle_one_n, pins.memory_read_n, pins.port_read_n,
         pins.memory_store_n};
      while (act() && n < 80) begin
         n++;
         @(negedge clock);
      end
      // No cycle seen, or a strobe that never ends
      if (n == 0 || n == 80) begin
         chk(16'h0, 16'h1);
         wrap_up();
      end
   endtask: watch
   task automatic issue(input cbi_pkg::cbi_kind_t k, input logic [15:0] ad);
      bwait(0);
      req = '{kind: k, addr: ad, wdata: 8'hC3};
      req_valid = 1'b1;
      @(negedge clock);
      req_valid = 1'b0;
      c0 = cyc;
   endtask: issue
   task automatic t_boot;
      watch();
      chk(a, 16'h0000);
      chk(16'(sig), 16'h2);
      chk(16'(n), 16'h2);
      chk(16'(pins.addr[15:7]), 16'h0);
      @(negedge clock);
      chk(16'(op_valid), 16'h0);
      @(negedge clock);
      chk(16'(op_valid), 16'h1);
      chk(16'(op_byte), 16'(mem(16'h0)));
      $display("boot fetch test done");
   endtask: t_boot
   task automatic t_cyc(input cbi_pkg::cbi_kind_t k, input logic [15:0] ad,
      input logic [3:0] es, input int en);
      issue(k, ad);
      watch();
      chk(a, ad);
      chk(16'(sig), 16'(es));
      // Port strobes start in the second state, so every strobe is three
      chk(16'(n), 16'h3);
      bwait(1);
      chk(16'(cyc - c0), 16'(en));
      if (k == cbi_pkg::CBI_MEM_WR || k == cbi_pkg::CBI_PORT_WR)
         chk(16'(d), 16'h01C3);
      if (k == cbi_pkg::CBI_MEM_RD || k == cbi_pkg::CBI_PORT_RD)
         chk(16'(rsp_data), 16'(mem(ad)));
      $display("bus cycle test done");
   endtask: t_cyc
   task automatic t_wait(input cbi_pkg::cbi_kind_t k, input int least);
      slow = 1'b1;
      repeat (6) @(negedge clock);
      issue(k, 16'h2000);
      watch();
      chk(16'(n > least), 16'h1);
      bwait(1);
      slow = 1'b0;
      $display("wait state test done");
   endtask: t_wait
   task automatic t_hold;
      bus_hold_req_n = 1'b0;
      bwait(2);
      chk(16'({pins.addr_oe, pins.dout_oe, pins.legacy_oe, pins.fast_oe}),
         16'h0);
      repeat (10) @(negedge clock);
      chk(16'(bus_grant_n), 16'h0);
      bus_hold_req_n = 1'b1;
      bwait(3);
      chk(16'({op_valid, op_byte}), 16'({1'b1, mem(16'h0)}));
      $display("bus release test done");
   endtask: t_hold
   task automatic t_nmi;
      nonmask_irq_n = 1'b0;
      repeat (6) @(negedge clock);
      nonmask_irq_n = 1'b1;
      bwait(0);
      instr.done = 1'b1;
      @(negedge clock);
      instr.done = 1'b0;
      watch();
      chk(a, 16'h0001);
      bwait(5);
      chk(16'(irq.nmi), 16'h1);
      chk(irq.push_pc, 16'h0001);
      watch();
      chk(a, 16'h0066);
      chk(pins.addr, 16'h0002);
      bwait(0);
      instr = '{done: 1'b1, jump: 1'b1, target: 16'h0001, default: '0};
      @(negedge clock);
      instr = '0;
      watch();
      chk(a, 16'h0001);
      $display("interrupt test done");
   endtask: t_nmi
   task automatic t_int;
      bwait(0);
      instr = '{done: 1'b1, halt: 1'b1, set_ie: 1'b1, default: '0};
      @(negedge clock);
      instr = '0;
      bwait(4);
      repeat (12) @(negedge clock);
      chk(16'(stopped_n), 16'h0);
      maskable_irq_n = 1'b0;
      bwait(5);
      chk(16'(irq.mode), 16'h1);
      chk(16'(irq.nmi), 16'h0);
      chk(irq.push_pc, 16'h0001);
      watch();
      chk(a, 16'h0038);
      chk(16'(stopped_n), 16'h1);
      maskable_irq_n = 1'b1;
      $display("halt and maskable interrupt test done");
   endtask: t_int
   initial begin
      repeat (8) @(negedge clock);
      rst_b = 1'b1;
      t_boot();
      t_cyc(cbi_pkg::CBI_MEM_RD, 16'h1234, 4'hA, 3);
      t_cyc(cbi_pkg::CBI_PORT_RD, 16'h0042, 4'hC, 4);
      t_cyc(cbi_pkg::CBI_PORT_WR, 16'h0043, 4'hD, 4);
      t_wait(cbi_pkg::CBI_MEM_WR, 3);
      t_wait(cbi_pkg::CBI_PORT_WR, 4);
      t_hold();
      t_nmi();
      mode_select = 1'b0;
      repeat (8) @(negedge clock);
      t_cyc(cbi_pkg::CBI_MEM_RD, 16'h0F0F, 4'hB, 3);
      t_cyc(cbi_pkg::CBI_PORT_RD, 16'h0081, 4'hD, 4);
      t_int();
      wrap_up();
   end
endmodule: cbi_bus_seq_tb
`default_nettype wire
